// File: hdl/wdt_pkg.sv
/*
  wdt_pkg: constants and types for the watchdog one-shot timer.
  assumes a single core clock domain at 100 MHz; the rc oscillator arrives as a pin.
*/
`default_nettype none
package wdt_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] WDT_BANK_F      = 4'hF;   // expanded register bank
  localparam logic [3:0] WDT_MODE_ADDR   = 4'hF;   // location within the bank
  localparam logic [7:0] WDT_MODE_RESET  = 8'h0D;  // default mode after reset
  localparam logic [7:0] WDT_READ_VALUE  = 8'hFF;  // returned on a read of the slot
  localparam int         WDT_TAP_LSB     = 0;
  localparam int         WDT_HALT_BIT    = 2;
  localparam int         WDT_STOP_BIT    = 3;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int         WDT_WINDOW_CYC  = 60;     // processor cycles of open window
  localparam logic [6:0] WDT_WINDOW_LAST = 7'(WDT_WINDOW_CYC - 1);
  localparam int         WDT_CNT_W       = 16;
  localparam logic [WDT_CNT_W-1:0] WDT_TAP0 = 16'h0100;
  localparam logic [WDT_CNT_W-1:0] WDT_TAP1 = 16'h0200;
  localparam logic [WDT_CNT_W-1:0] WDT_TAP2 = 16'h0400;
  localparam logic [WDT_CNT_W-1:0] WDT_TAP3 = 16'h1000;
  localparam int         WDT_POR_TICKS   = 16;     // rc ticks of power-on reset hold
  localparam logic [4:0] WDT_POR_LAST    = 5'(WDT_POR_TICKS);
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rsvd;      // stored but unused
    logic       stop_run;
    logic       halt_run;
    logic [1:0] tap;
  } wdt_mode_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] bank;
    logic [3:0] addr;
    logic [7:0] data;
  } wdt_reg_req_t;
  typedef enum logic [1:0] {
    WDT_IDLE = 2'b00,
    WDT_RUN  = 2'b01,
    WDT_FIRE = 2'b11
  } wdt_state_t;
endpackage
`default_nettype wire

// File: hdl/wdt_top.sv
/*
  wdt_top: watchdog one-shot timer, mode register and power-on reset timing.
  assumes the core gives a one-cycle refresh pulse per refresh instruction and
  a one-cycle pulse per processor cycle; the rc oscillator is an asynchronous pin.
*/
`default_nettype none
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         rc_osc_i,
  input  wire logic         cpu_cycle_i,
  input  wire logic         refresh_i,
  input  wire logic         halt_i,
  input  wire logic         stop_i,
  input  wire logic         stop_recover_i,
  input  wire wdt_reg_req_t reg_req_i,
  output logic [7:0]        reg_rdata_o,
  output logic              reg_rvalid_o,
  output logic [2:0]        flag_zsv_o,
  output logic              flag_we_o,
  output logic              core_reset_o,
  output logic              por_done_o,
  output logic              wdt_running_o
);
  // ------------------------------------------------------------
  // rc oscillator synchroniser and tick
  // ------------------------------------------------------------
  logic [2:0] rc_sync_q, rc_sync_d;
  logic       rc_lvl_q, rc_lvl_d;
  logic       rc_tick;

  // three stages; a level change counts once the second and third agree
  always_comb begin
    rc_sync_d = {rc_sync_q[1:0], rc_osc_i};
    rc_lvl_d  = (rc_sync_q[1] == rc_sync_q[2]) ? rc_sync_q[2] : rc_lvl_q;
  end
  assign rc_tick = rc_lvl_d & ~rc_lvl_q;  // rising edge of filtered rc level

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_sync_q <= 3'h0;
      rc_lvl_q  <= 1'b0;
    end else begin
      rc_sync_q <= rc_sync_d;
      rc_lvl_q  <= rc_lvl_d;
    end
  end

  // ------------------------------------------------------------
  // power-on reset timing
  // ------------------------------------------------------------
  logic [4:0] por_cnt_q, por_cnt_d;
  logic       por_done_q, por_done_d;

  // core stays in reset until enough rc ticks pass after release
  always_comb begin
    por_cnt_d  = por_cnt_q;
    por_done_d = por_done_q;
    if (!por_done_q && rc_tick) begin
      por_cnt_d = por_cnt_q + 5'h01;
      if (por_cnt_d == WDT_POR_LAST) begin
        por_done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_cnt_q  <= 5'h00;
      por_done_q <= 1'b0;
    end else begin
      por_cnt_q  <= por_cnt_d;
      por_done_q <= por_done_d;
    end
  end

  // ------------------------------------------------------------
  // mode register and its write window
  // ------------------------------------------------------------
  wdt_mode_t  mode_q, mode_d;
  logic [6:0] win_cnt_q, win_cnt_d;
  logic       win_open_q, win_open_d;
  logic       mode_hit;
  logic       wdt_fire;

  // bank F, location 0Fh
  always_comb begin
    if (reg_req_i.bank == WDT_BANK_F && reg_req_i.addr == WDT_MODE_ADDR) begin
      mode_hit = 1'b1;
    end else begin
      mode_hit = 1'b0;
    end
  end

  // the window reopens after watchdog reset or stop recovery, not on mere refresh;
  // stop recovery keeps the stored mode while a watchdog reset restores defaults
  always_comb begin
    mode_d     = mode_q;
    win_cnt_d  = win_cnt_q;
    win_open_d = win_open_q;
    if (wdt_fire) begin
      mode_d     = wdt_mode_t'(WDT_MODE_RESET);
      win_cnt_d  = 7'h00;
      win_open_d = 1'b1;
    end else if (stop_recover_i) begin
      win_cnt_d  = 7'h00;                                          // mode kept
      win_open_d = 1'b1;
    end else begin
      if (win_open_q && por_done_q && reg_req_i.wr && mode_hit) begin
        mode_d = wdt_mode_t'(reg_req_i.data);
      end
      // counting starts with the first processor cycle after power-on timing is done
      if (win_open_q && por_done_q && cpu_cycle_i) begin
        win_cnt_d = win_cnt_q + 7'h01;
        if (win_cnt_q == WDT_WINDOW_LAST) begin
          win_open_d = 1'b0;                                       // locked until a watchdog reset or stop recovery
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q     <= wdt_mode_t'(WDT_MODE_RESET);
      win_cnt_q  <= 7'h00;
      win_open_q <= 1'b1;
    end else begin
      mode_q     <= mode_d;
      win_cnt_q  <= win_cnt_d;
      win_open_q <= win_open_d;
    end
  end

  // ------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------
  wdt_state_t           st_q, st_d;
  logic [WDT_CNT_W-1:0] cnt_q, cnt_d;
  logic [WDT_CNT_W-1:0] tap_limit;
  logic                 count_en;

  // longer period for larger code; reserved bits never read here
  always_comb begin
    case (mode_q.tap)
      2'b00:   tap_limit = WDT_TAP0;
      2'b01:   tap_limit = WDT_TAP1;
      2'b10:   tap_limit = WDT_TAP2;
      default: tap_limit = WDT_TAP3;
    endcase
  end

  // low-power states suspend counting unless their activity bit is set
  assign count_en = rc_tick
                  & (~halt_i | mode_q.halt_run)
                  & (~stop_i | mode_q.stop_run);
  assign wdt_fire = (st_q == WDT_FIRE);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      WDT_IDLE: begin
        if (refresh_i) begin
          st_d  = WDT_RUN;                                         // first refresh arms
          cnt_d = '0;
        end
      end
      WDT_RUN: begin
        if (refresh_i) begin
          cnt_d = '0;                                              // retrigger
        end else if (count_en) begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_d >= tap_limit) begin
            st_d = WDT_FIRE;                                       // terminal count
          end
        end
      end
      default: begin
        // one-cycle core reset; watchdog disarms until armed again
        st_d  = WDT_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q  <= WDT_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic [7:0] rdata_d;
  logic       rvalid_d;
  logic [2:0] flags_d;
  logic       flag_we_d;
  logic       core_rst_d;
  logic       running_d;

  // reads of the mode slot give a constant, never the stored mode
  always_comb begin
    rvalid_d   = reg_req_i.rd & mode_hit;
    rdata_d    = rvalid_d ? WDT_READ_VALUE : 8'h00;
    flag_we_d  = refresh_i;
    flags_d    = refresh_i ? 3'h0 : flag_zsv_o;                    // z,s,v cleared
    core_rst_d = (st_d == WDT_FIRE) | ~por_done_d;
    running_d  = (st_d == WDT_RUN);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o   <= 8'h00;
      reg_rvalid_o  <= 1'b0;
      flag_zsv_o    <= 3'h0;
      flag_we_o     <= 1'b0;
      core_reset_o  <= 1'b1;
      por_done_o    <= 1'b0;
      wdt_running_o <= 1'b0;
    end else begin
      reg_rdata_o   <= rdata_d;
      reg_rvalid_o  <= rvalid_d;
      flag_zsv_o    <= flags_d;
      flag_we_o     <= flag_we_d;
      core_reset_o  <= core_rst_d;
      por_done_o    <= por_done_d;
      wdt_running_o <= running_d;
    end
  end
endmodule
`default_nettype wire

// File: verification/wdt_core_model.sv
/*
  wdt_core_model: stand-in for the processor core clocking and the rc oscillator.
  assumes the bench drives refresh, halt, stop and register requests itself.
*/
`default_nettype none
module wdt_core_model #(
  parameter int RC_HALF = 37
) (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  output var  logic rc_osc_o,
  output var  logic cpu_cycle_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // rc oscillator runs free, out of phase with the core clock
  initial rc_osc_o = 1'b0;
  always #(RC_HALF) rc_osc_o = ~rc_osc_o;
  // one processor cycle per two crystal clocks, so 60 cycles span 120 clocks
  always_ff @(negedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      cpu_cycle_o <= 1'b0;
    else
      cpu_cycle_o <= ~cpu_cycle_o;
  end
endmodule
`default_nettype wire

// File: verification/wdt_properties.sv
/*
  wdt_checker: port-level properties of the watchdog.
  assumes it is bound into wdt_top and sees only its ports.
*/
`default_nettype none
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic         core_clk_i,
  input wire logic         rst_b_i,
  input wire logic         rc_osc_i,
  input wire logic         cpu_cycle_i,
  input wire logic         refresh_i,
  input wire logic         halt_i,
  input wire logic         stop_i,
  input wire logic         stop_recover_i,
  input wire wdt_reg_req_t reg_req_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire logic         reg_rvalid_o,
  input wire logic [2:0]   flag_zsv_o,
  input wire logic         flag_we_o,
  input wire logic         core_reset_o,
  input wire logic         por_done_o,
  input wire logic         wdt_running_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  flag_write_a: assert property (refresh_i |=> flag_we_o && flag_zsv_o == 3'h0)
    else $error("flag update missing after refresh");
  flag_cause_a: assert property (flag_we_o |-> $past(refresh_i))
    else $error("flag update without refresh");
  first_arm_a: assert property (refresh_i && por_done_o && !core_reset_o |=> wdt_running_o)
    else $error("refresh did not arm");
  arm_cause_a: assert property ($rose(wdt_running_o) |-> $past(refresh_i))
    else $error("armed without refresh");
  slot_read_a: assert property (reg_req_i.rd && reg_req_i.bank == WDT_BANK_F &&
    reg_req_i.addr == WDT_MODE_ADDR |=> reg_rvalid_o && reg_rdata_o == WDT_READ_VALUE)
    else $error("mode slot read wrong");
  miss_read_a: assert property (reg_req_i.rd && reg_req_i.addr != WDT_MODE_ADDR
    |=> !reg_rvalid_o) else $error("read hit outside slot");
  fire_pulse_a: assert property (por_done_o && core_reset_o |=> !core_reset_o)
    else $error("core reset longer than one cycle");
  fire_disarm_a: assert property (por_done_o && core_reset_o |=> !wdt_running_o)
    else $error("still armed after fire");
  por_end_a: assert property ($rose(por_done_o) |-> $fell(core_reset_o))
    else $error("power-on timing end misaligned");
  refresh_wins_a: assert property (wdt_running_o && refresh_i |=> !core_reset_o)
    else $error("fire despite refresh");
  cover property (por_done_o && core_reset_o);
  cover property (wdt_running_o && refresh_i);
  cover property (reg_rvalid_o);
endmodule
bind wdt_top wdt_checker chk (.*);
`default_nettype wire

// File: verification/test_wdt_top.sv
/*
  test_wdt_top: self-checking bench for the watchdog one-shot timer.
  assumes wdt_core_model supplies the rc oscillator and processor cycles.
*/
`default_nettype none
module test_wdt_top;
  import wdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, cyc, rc, refresh = 0, halt = 0, stop = 0, recov = 0;
  wdt_reg_req_t req = '0;
  logic [7:0] rdata;
  logic [2:0] fzsv;
  logic rvalid, fwe, crst, pdone, run;
  int n_errors = 0, checked = 0, seed = 32'he1e2b66d;
  always #5 clk = ~clk;
  wdt_top DUT (.core_clk_i(clk), .rst_b_i(rst_b), .rc_osc_i(rc), .cpu_cycle_i(cyc),
    .refresh_i(refresh), .halt_i(halt), .stop_i(stop), .stop_recover_i(recov),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .flag_zsv_o(fzsv),
    .flag_we_o(fwe), .core_reset_o(crst), .por_done_o(pdone), .wdt_running_o(run));
  wdt_core_model core (.core_clk_i(clk), .rst_b_i(rst_b), .rc_osc_o(rc), .cpu_cycle_o(cyc));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    checked++;
    // an unknown result counts as a failure, never as a pass
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one register cycle; read data is looked at right after the taking edge
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: wr, rd: !wr, bank: WDT_BANK_F, addr: addr, data: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic refr();
    @(negedge clk);
    refresh = 1'b1;
    @(negedge clk);
    refresh = 1'b0;
    check(fwe === 1'b1 && fzsv === 3'h0, "flag update after refresh");
  endtask
  // expected wait is ticks times the 74 ns rc period, with slack for the filter
  task automatic wait_fire(input logic arm, input int ticks);
    int n;
    n = 0;
    if (arm)
      refr();
    while (crst !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    check(n < 40000 && (n - ticks * 74 / 10) inside {[-30:30]}, "timeout period wrong");
    if (n >= 40000)
      end_of_test();
  endtask
  task automatic quiet(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clk);
      if (crst !== 1'b0)
        ok = 1'b0;
    end
    check(ok && run === 1'b1, "count ran while suspended");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int i;
    i = 0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    while (pdone !== 1'b1 && i < 1000) begin
      @(negedge clk);
      i++;
    end
    check(pdone === 1'b1 && crst === 1'b0, "power-on timing");
    if (i >= 1000)
      end_of_test();
    bus(1'b0, WDT_MODE_ADDR, 8'h00);
    check(rvalid === 1'b1 && rdata === WDT_READ_VALUE, "mode slot read");
    bus(1'b0, 4'hE, 8'h00);
    check(rvalid === 1'b0, "read outside slot");
    // tap 0, random reserved bits; a refresh midway restarts the count
    bus(1'b1, WDT_MODE_ADDR, {4'($random(seed)), 4'hC});
    check(run === 1'b0, "armed before first refresh");
    refr();
    repeat (500 + ($random(seed) & 255)) @(negedge clk);
    check(crst === 1'b0 && run === 1'b1, "early fire");
    wait_fire(1'b1, 'h100);
    // late write is ignored; the default tap after a watchdog reset applies
    repeat (200) @(negedge clk);
    bus(1'b1, WDT_MODE_ADDR, 8'h0C);
    wait_fire(1'b1, 'h200);
    // suspend in halt and stop; stop recovery keeps the written mode
    bus(1'b1, WDT_MODE_ADDR, 8'h00);
    @(negedge clk);
    recov = 1'b1;
    @(negedge clk);
    recov = 1'b0;
    refr();
    halt = 1'b1;
    quiet(2500);
    halt = 1'b0;
    stop = 1'b1;
    quiet(2500);
    stop = 1'b0;
    wait_fire(1'b0, 'h100);
    end_of_test();
  end
endmodule
`default_nettype wire
